// ---- rtl/rtc_flags_and_century.sv ----
/*
 * Flags/control and century registers of the RTC, reached over the async
 * SRAM bus pins. Assumes watchdog, alarm time fields, oscillator status and
 * the normal interrupt level come from same-clock RTC logic.
 */
// Functional notes
// - century is two BCD digits, top bits zero
// - watchdog expiry sets bit 7, read clears
// - alarm match sets bit 6, read clears
// - supply drop sets bit 5, read clears
// - oscillator dead first 5 ms sets bit 4
// - oscillator flag persists, only host clears
// - calibration bit gives 512 Hz on interrupt pin
// - calibration bit resets to zero
// - write-enable bit freezes clock register updates
// - protected writes accepted only with write-enable
// - write-enable falling loads new base time only when i_time_dirty is set
// - write-enable bit resets to zero
// - alarm match bit one ignores field
module rtc_flags_and_century
    import rtc_flags_pkg::*;
#(
    parameter int unsigned OSC_WAIT = OSC_WAIT_CYC
) (
    input  wire logic        i_mclk,
    input  wire logic        i_nrst,
    input  wire logic [16:0] i_addr,
    input  wire logic [7:0]  i_dq,
    input  wire logic        i_ce_n,
    input  wire logic        i_we_n,
    input  wire logic        i_oe_n,
    input  wire logic        i_supply_threshold,
    input  wire logic        i_osc_running,
    input  wire logic        i_osc_enable,
    input  wire logic        i_osc_lost_saved,
    input  wire logic        i_dog_zero,
    input  wire logic [31:0] i_time_now,
    input  wire logic [31:0] i_alarm_set,
    input  wire logic        i_time_dirty,
    input  wire logic        i_int_normal,
    output logic      [7:0]  o_dq,
    output logic             o_dq_oe,
    output logic             o_int_pin,
    output logic             o_freeze_updates,
    output logic             o_hold_freeze,
    output logic             o_load_base,
    output logic             o_osc_lost_flag
);
    typedef struct packed {
        logic [1:0]  ce_s;
        logic [1:0]  we_s;
        logic [1:0]  oe_s;
        logic [1:0]  low_s;
        logic [1:0]  run_s;
        logic [16:0] addr_s1;
        logic [16:0] addr_s2;
        logic [7:0]  dq_s1;
        logic [7:0]  dq_s2;
        logic [16:0] waddr;
        logic [7:0]  wdata;
        logic        rd_prev;
        logic        wr_prev;
        logic        alarm_prev;
        logic        low_prev;
        logic        boot;
        logic        osc_busy;
        logic        osc_seen;
        logic        dog_expiry_flag;
        logic        alarm_hit_flag;
        logic        supply_drop_flag;
        logic        osc_lost_flag;
        logic        cal;
        logic        wren;
        logic        snap;
        logic [5:0]  century;
        logic [7:0]  rdata;
        logic        dq_oe;
        logic        int_pin;
        logic        load_base;
    } state_t;

    state_t st_ff;
    state_t nxt_st;
    logic   osc_window_end;
    logic   cal_tick;

    // masked field-by-field compare of four BCD time bytes
    function automatic logic alarm_equal(input logic [31:0] now, input logic [31:0] set);
        logic hit;
        hit = 1'b1;
        for (int i = 0; i < 4; i++) begin
            if ((set[i*8 +: 8] & ALARM_MASK_M) == 8'h00 &&
                (now[i*8 +: 7] != set[i*8 +: 7])) begin
                hit = 1'b0;
            end
        end
        return hit;
    endfunction

    function automatic logic [7:0] flags_view(input state_t s);
        logic [7:0] v;
        v            = 8'h00;
        v[DOG_BIT]    = s.dog_expiry_flag;
        v[ALARM_BIT]  = s.alarm_hit_flag;
        v[SUPPLY_BIT] = s.supply_drop_flag;
        v[OSC_BIT]    = s.osc_lost_flag;
        v[CAL_BIT]    = s.cal;
        v[WREN_BIT]   = s.wren;
        v[SNAP_BIT]   = s.snap;
        return v;
    endfunction

    rtc_tick_div #(.COUNT(OSC_WAIT)) u_osc_div (
        .i_mclk (i_mclk),
        .i_nrst (i_nrst),
        .i_en   (st_ff.osc_busy),
        .o_tick (osc_window_end)
    );

    rtc_tick_div #(.COUNT(CAL_HALF_CYC)) u_cal_div (
        .i_mclk (i_mclk),
        .i_nrst (i_nrst),
        .i_en   (st_ff.cal),
        .o_tick (cal_tick)
    );

    logic rd_act;
    logic wr_act;
    logic rd_end;
    logic wr_end;
    logic flags_sel;
    logic cent_sel;
    logic wflags_sel;
    logic wcent_sel;
    logic clr_status;
    logic alarm_now;
    logic dog_set;
    logic alarm_set;
    logic low_set;

    always_comb begin
        nxt_st = st_ff;
        // pins pass two stages before any decode
        nxt_st.ce_s    = {st_ff.ce_s[0], ~i_ce_n};
        nxt_st.we_s    = {st_ff.we_s[0], ~i_we_n};
        nxt_st.oe_s    = {st_ff.oe_s[0], ~i_oe_n};
        nxt_st.low_s   = {st_ff.low_s[0], i_supply_threshold};
        nxt_st.run_s   = {st_ff.run_s[0], i_osc_running};
        nxt_st.addr_s1 = i_addr;
        nxt_st.addr_s2 = st_ff.addr_s1;
        nxt_st.dq_s1   = i_dq;
        nxt_st.dq_s2   = st_ff.dq_s1;

        rd_act    = st_ff.ce_s[1] & st_ff.oe_s[1] & ~st_ff.we_s[1];
        wr_act    = st_ff.ce_s[1] & st_ff.we_s[1];
        rd_end    = st_ff.rd_prev & ~rd_act;
        wr_end    = st_ff.wr_prev & ~wr_act;
        flags_sel = st_ff.addr_s2 == FLAGS_ADDR;
        cent_sel  = st_ff.addr_s2 == CENT_ADDR;
        nxt_st.rd_prev = rd_act;
        nxt_st.wr_prev = wr_act;
        // hold the write while strobes stand; the host may drop data on release
        if (wr_act) begin
            nxt_st.waddr = st_ff.addr_s2;
            nxt_st.wdata = st_ff.dq_s2;
        end
        wflags_sel = st_ff.waddr == FLAGS_ADDR;
        wcent_sel  = st_ff.waddr == CENT_ADDR;

        // clear after the read ends so the host sees the flags it read
        clr_status = rd_end & flags_sel;
        alarm_now  = alarm_equal(i_time_now, i_alarm_set);
        dog_set    = i_dog_zero;
        alarm_set  = alarm_now & ~st_ff.alarm_prev;
        low_set    = st_ff.low_s[1] & ~st_ff.low_prev;
        nxt_st.alarm_prev = alarm_now;
        nxt_st.low_prev   = st_ff.low_s[1];

        // an event in the clearing cycle wins over the clear
        nxt_st.dog_expiry_flag  = dog_set | (st_ff.dog_expiry_flag & ~clr_status);
        nxt_st.alarm_hit_flag   = alarm_set | (st_ff.alarm_hit_flag & ~clr_status);
        nxt_st.supply_drop_flag = low_set | (st_ff.supply_drop_flag & ~clr_status);

        // oscillator check over the first window after power-up
        nxt_st.boot = 1'b0;
        if (st_ff.boot) begin
            nxt_st.osc_lost_flag = i_osc_lost_saved;
            nxt_st.osc_busy      = 1'b1;
        end
        if (st_ff.osc_busy && st_ff.run_s[1]) begin
            nxt_st.osc_seen = 1'b1;
        end
        if (osc_window_end) begin
            nxt_st.osc_busy = 1'b0;
            if (i_osc_enable && !st_ff.osc_seen && !st_ff.run_s[1]) begin
                nxt_st.osc_lost_flag = 1'b1;
            end
        end

        nxt_st.load_base = 1'b0;
        if (wr_end && wflags_sel) begin
            nxt_st.snap = st_ff.wdata[SNAP_BIT];
            nxt_st.wren = st_ff.wdata[WREN_BIT];
            if (st_ff.wren) begin
                nxt_st.cal = st_ff.wdata[CAL_BIT];
                // host may only clear; a new failure in this cycle still wins
                if (!st_ff.wdata[OSC_BIT] && !(osc_window_end && i_osc_enable &&
                    !st_ff.osc_seen && !st_ff.run_s[1]) && !st_ff.boot) begin
                    nxt_st.osc_lost_flag = 1'b0;
                end
            end
            if (st_ff.wren && !st_ff.wdata[WREN_BIT] && i_time_dirty) begin
                nxt_st.load_base = 1'b1;
            end
        end
        if (wr_end && wcent_sel && st_ff.wren) begin
            nxt_st.century = st_ff.wdata[5:0];
        end

        // read data captured in the first cycle of a read, then held
        nxt_st.dq_oe = rd_act & (flags_sel | cent_sel);
        if (rd_act && !st_ff.rd_prev) begin
            nxt_st.rdata = flags_sel ? flags_view(st_ff) : {2'b00, st_ff.century};
        end

        // calibration square wave replaces the normal interrupt level
        if (st_ff.cal) begin
            nxt_st.int_pin = cal_tick ? ~st_ff.int_pin : st_ff.int_pin;
        end else begin
            nxt_st.int_pin = i_int_normal;
        end
    end

    always_ff @(posedge i_mclk or negedge i_nrst) begin
        if (!i_nrst) begin
            st_ff         <= '0;
            st_ff.boot    <= 1'b1;
            st_ff.cal     <= 1'b0;
            st_ff.wren    <= 1'b0;
            st_ff.century <= CENT_RESET;
        end else begin
            st_ff <= nxt_st;
        end
    end

    assign o_dq             = st_ff.rdata;
    assign o_dq_oe          = st_ff.dq_oe;
    assign o_int_pin        = st_ff.int_pin;
    assign o_freeze_updates = st_ff.wren;
    // counters are not held here; only the holding copy freezes
    assign o_hold_freeze    = st_ff.snap;
    assign o_load_base      = st_ff.load_base;
    assign o_osc_lost_flag  = st_ff.osc_lost_flag;

    default clocking cb @(posedge i_mclk); endclocking
    default disable iff (!i_nrst);

    AST_CENT_TOP_ZERO: assert property (st_ff.dq_oe && st_ff.rdata[7:6] != 2'b00 |->
        st_ff.addr_s2 == FLAGS_ADDR)
        else $error("century read shows nonzero top bits");
    AST_DOG_SET: assert property (i_dog_zero |=> st_ff.dog_expiry_flag)
        else $error("watchdog expiry not flagged");
    AST_STATUS_CLEAR: assert property (rd_end && flags_sel && !i_dog_zero |=>
        !st_ff.dog_expiry_flag)
        else $error("flags read did not clear watchdog flag");
    AST_ALARM_SET: assert property (alarm_set |=> st_ff.alarm_hit_flag)
        else $error("alarm match not flagged");
    AST_LOW_SET: assert property ($rose(st_ff.low_s[1]) |=> st_ff.supply_drop_flag)
        else $error("supply drop not flagged");
    AST_OSC_KEEP: assert property (st_ff.osc_lost_flag &&
        !(wr_end && wflags_sel && st_ff.wren) |=> st_ff.osc_lost_flag)
        else $error("oscillator flag cleared without host write");
    AST_CAL_WAVE: assert property (st_ff.cal && cal_tick |=> $changed(st_ff.int_pin))
        else $error("calibration wave did not toggle");
    AST_NORMAL_INT: assert property (!st_ff.cal && !$past(st_ff.cal) |=>
        o_int_pin == $past(i_int_normal))
        else $error("interrupt pin not following normal level");
    AST_LOCKED_WRITE: assert property (!st_ff.wren |=>
        st_ff.century == $past(st_ff.century))
        else $error("century changed while writes locked");
    AST_LOAD_PULSE: assert property (o_load_base |-> !st_ff.wren ##1 !o_load_base)
        else $error("base load pulse malformed");
    AST_BIT3_ZERO: assert property (st_ff.dq_oe && flags_sel |-> !st_ff.rdata[3])
        else $error("flags bit 3 not zero");

    COV_FLAGS_READ: cover property (rd_end && flags_sel && st_ff.alarm_hit_flag);
    COV_CAL_ON: cover property (st_ff.cal && cal_tick);
    COV_BASE_LOAD: cover property (o_load_base);
    COV_OSC_LOST: cover property ($rose(st_ff.osc_lost_flag));
endmodule // rtc_flags_and_century

// ---- pkg/rtc_flags_pkg.sv ----
/*
 * Constants for the flags/control and century registers of the RTC.
 * Assumes a 100 MHz system clock and a 17-bit byte address on the SRAM bus.
 */
package rtc_flags_pkg;
    localparam int unsigned ADDR_W        = 17;
    localparam logic [16:0] FLAGS_ADDR    = 17'h1FFF0;
    localparam logic [16:0] CENT_ADDR     = 17'h1FFF1;
    // flags_and_control bit positions
    localparam int unsigned DOG_BIT       = 7;
    localparam int unsigned ALARM_BIT     = 6;
    localparam int unsigned SUPPLY_BIT    = 5;
    localparam int unsigned OSC_BIT       = 4;
    localparam int unsigned CAL_BIT       = 2;
    localparam int unsigned WREN_BIT      = 1;
    localparam int unsigned SNAP_BIT      = 0;
    // century_count layout
    localparam int unsigned CENT_W        = 6;
    localparam logic [5:0]  CENT_RESET    = 6'h00;
    localparam logic [7:0]  ALARM_MASK_M  = 8'h80;
    // timing
    localparam int unsigned CLK_PERIOD_NS = 10;
    localparam int unsigned OSC_WAIT_NS   = 5_000_000;
    localparam int unsigned OSC_WAIT_CYC  = OSC_WAIT_NS / CLK_PERIOD_NS;
    localparam int unsigned CAL_HZ        = 512;
    localparam int unsigned CAL_HALF_CYC  = 1_000_000_000 / (CLK_PERIOD_NS * CAL_HZ * 2);
endpackage : rtc_flags_pkg

// ---- rtl/rtc_tick_div.sv ----
/*
 * Enable-gated divider: one-cycle pulse every COUNT enabled cycles.
 * Assumes the enable is from the same clock; dropping it restarts the count.
 */
module rtc_tick_div #(
    parameter int unsigned COUNT = 16
) (
    input  wire logic i_mclk,
    input  wire logic i_nrst,
    input  wire logic i_en,
    output logic      o_tick
);
    typedef struct packed {
        logic [19:0] cnt;
        logic        tick;
    } div_t;

    localparam logic [19:0] LAST = 20'(COUNT - 1);

    div_t st_ff;
    div_t nxt_st;

    always_comb begin
        nxt_st      = st_ff;
        nxt_st.tick = 1'b0;
        if (!i_en) begin
            nxt_st.cnt = 20'h00000;
        end else if (st_ff.cnt == LAST) begin
            nxt_st.cnt  = 20'h00000;
            nxt_st.tick = 1'b1;
        end else begin
            nxt_st.cnt = st_ff.cnt + 20'h00001;
        end
    end

    always_ff @(posedge i_mclk or negedge i_nrst) begin
        if (!i_nrst) begin
            st_ff <= '0;
        end else begin
            st_ff <= nxt_st;
        end
    end

    assign o_tick = st_ff.tick;
endmodule // rtc_tick_div

// ---- verification/rtc_host_model.sv ----
/* Host processor on the async SRAM bus: byte write and read tasks.
   Assumes the bench calls the tasks one at a time; pins move on falling edges. */
module rtc_host_model (
    input  wire logic        i_mclk,
    input  wire logic [7:0]  i_rdata,
    input  wire logic        i_rdata_oe,
    output logic      [16:0] o_addr,
    output logic      [7:0]  o_dq,
    output logic             o_ce_n,
    output logic             o_we_n,
    output logic             o_oe_n
);
    timeunit 1ns;
    timeprecision 1ps;
    initial begin
        o_addr = 17'h00000;
        o_dq = 8'h00;
        o_ce_n = 1'b1;
        o_we_n = 1'b1;
        o_oe_n = 1'b1;
    end
    task automatic idle(input int n);
        repeat (n) @(negedge i_mclk);
    endtask
    // strobes held 5 cycles, 6 idle after: both above the 4 and 3 minimum
    task automatic wr(input logic [16:0] a, input logic [7:0] d);
        @(negedge i_mclk);
        o_addr = a;
        o_dq = d;
        o_ce_n = 1'b0;
        o_we_n = 1'b0;
        idle(5);
        o_ce_n = 1'b1;
        o_we_n = 1'b1;
        o_dq = ~d; // released bus shows no stale data
        idle(6);
    endtask
    task automatic rd(input logic [16:0] a, output logic [7:0] d);
        int n;
        n = 0;
        @(negedge i_mclk);
        o_addr = a;
        o_ce_n = 1'b0;
        o_oe_n = 1'b0;
        idle(4);
        while (i_rdata_oe !== 1'b1 && n < 20) begin
            n++;
            idle(1);
        end
        d = (i_rdata_oe === 1'b1) ? i_rdata : 8'hXX;
        o_ce_n = 1'b1;
        o_oe_n = 1'b1;
        idle(6);
    endtask
endmodule // rtc_host_model

// ---- verification/tb.sv ----
/* Self-checking bench for the flags/control and century registers.
   Assumes the host model drives the bus pins; all other inputs set here. */
module tb
    import rtc_flags_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;
    typedef struct packed {logic [16:0] a; logic [7:0] w; logic [7:0] e;} row_t;
    logic        mclk, nrst, ce_n, we_n, oe_n, supply, osc_run, osc_en, osc_saved;
    logic        dog, dirty, int_norm, roe, int_pin, frz, hold, load, osc_flag, p;
    logic [16:0] addr;
    logic [7:0]  dq, rdq;
    logic [31:0] time_now, alarm_set;
    int          miscompares, check_count, loads;
    const row_t  rows[5] = '{'{FLAGS_ADDR, 8'h02, 8'h02}, '{CENT_ADDR, 8'h99, 8'h19},
        '{CENT_ADDR, 8'hC5, 8'h05}, '{FLAGS_ADDR, 8'hEB, 8'h03},
        '{FLAGS_ADDR, 8'h06, 8'h06}};
    rtc_host_model host (.i_mclk(mclk), .i_rdata(rdq), .i_rdata_oe(roe), .o_addr(addr),
        .o_dq(dq), .o_ce_n(ce_n), .o_we_n(we_n), .o_oe_n(oe_n));
    // short window keeps the oscillator check cheap
    rtc_flags_and_century #(.OSC_WAIT(20)) i_dut (.i_mclk(mclk), .i_nrst(nrst),
        .i_addr(addr), .i_dq(dq), .i_ce_n(ce_n), .i_we_n(we_n), .i_oe_n(oe_n),
        .i_supply_threshold(supply), .i_osc_running(osc_run), .i_osc_enable(osc_en),
        .i_osc_lost_saved(osc_saved), .i_dog_zero(dog), .i_time_now(time_now),
        .i_alarm_set(alarm_set), .i_time_dirty(dirty), .i_int_normal(int_norm),
        .o_dq(rdq), .o_dq_oe(roe), .o_int_pin(int_pin), .o_freeze_updates(frz),
        .o_hold_freeze(hold), .o_load_base(load), .o_osc_lost_flag(osc_flag));
    initial begin
        mclk = 1'b0;
        forever #5 mclk = ~mclk;
    end
    always @(posedge mclk) if (load === 1'b1) loads++;
    task automatic end_of_test();
        $display("checks %0d mismatches %0d", check_count, miscompares);
        if (miscompares == 0 && check_count > 0)
            $display("== PASSED ==");
        else
            $display("== FAILED ==");
        $finish;
    endtask
    task automatic chk(input logic [7:0] g, input logic [7:0] e);
        check_count++;
        if (g !== e) begin
            miscompares++;
            $display("ERROR t=%0t got %h exp %h", $time, g, e);
        end
    endtask
    task automatic rdc(input logic [16:0] a, input logic [7:0] e);
        logic [7:0] d;
        host.rd(a, d);
        chk(d, e);
    endtask
    task automatic do_reset();
        @(negedge mclk);
        nrst = 1'b0;
        repeat (3) @(negedge mclk);
        nrst = 1'b1;
    endtask
    initial begin
        #60us;
        miscompares++;
        end_of_test();
    end
    initial begin
        {nrst, supply, osc_en, osc_saved, dog, dirty, int_norm} = '0;
        osc_run = 1'b1;
        time_now = 32'h00112233;
        alarm_set = 32'h00112234;
        do_reset();
        rdc(FLAGS_ADDR, 8'h00);
        rdc(CENT_ADDR, {2'b00, CENT_RESET});
        foreach (rows[i]) begin
            host.wr(rows[i].a, rows[i].w);
            rdc(rows[i].a, rows[i].e);
            if (rows[i].a == FLAGS_ADDR)
                chk({6'h00, frz, hold}, {6'h00, rows[i].e[1:0]});
        end
        // calibration on: the pin must not follow the normal level
        p = int_pin;
        repeat (10) begin
            @(negedge mclk);
            int_norm = ~int_norm;
        end
        chk({7'h00, int_pin}, {7'h00, p});
        host.wr(FLAGS_ADDR, 8'h02);
        int_norm = 1'b1;
        host.idle(3);
        chk({7'h00, int_pin}, 8'h01);
        host.wr(FLAGS_ADDR, 8'h00);
        host.wr(CENT_ADDR, 8'h42);
        rdc(CENT_ADDR, 8'h05);
        chk(loads[7:0], 8'h00);
        host.wr(FLAGS_ADDR, 8'h02);
        dirty = 1'b1;
        host.wr(FLAGS_ADDR, 8'h00);
        dirty = 1'b0;
        chk(loads[7:0], 8'h01);
        @(negedge mclk);
        dog = 1'b1;
        @(negedge mclk);
        dog = 1'b0;
        rdc(FLAGS_ADDR, 8'h80);
        rdc(FLAGS_ADDR, 8'h00);
        supply = 1'b1;
        rdc(FLAGS_ADDR, 8'h20);
        rdc(FLAGS_ADDR, 8'h00);
        supply = 1'b0;
        alarm_set = time_now;
        rdc(FLAGS_ADDR, 8'h40);
        rdc(FLAGS_ADDR, 8'h00);
        alarm_set = 32'h00112234;
        host.idle(4);
        alarm_set = 32'h00112280; // seconds field masked out
        rdc(FLAGS_ADDR, 8'h40);
        // no standing match across reset, or it would flag again
        alarm_set = 32'h00112234;
        osc_run = 1'b0;
        osc_en = 1'b1;
        do_reset();
        host.idle(40);
        chk({7'h00, osc_flag}, 8'h01);
        rdc(FLAGS_ADDR, 8'h10);
        rdc(FLAGS_ADDR, 8'h10);
        host.wr(FLAGS_ADDR, 8'h02);
        host.wr(FLAGS_ADDR, 8'h02);
        rdc(FLAGS_ADDR, 8'h02);
        chk({7'h00, osc_flag}, 8'h00);
        // saved flag survives a power cycle even with a running oscillator
        osc_saved = 1'b1;
        osc_run = 1'b1;
        do_reset();
        host.idle(40);
        rdc(FLAGS_ADDR, 8'h10);
        chk({7'h00, osc_flag}, 8'h01);
        end_of_test();
    end
endmodule // tb
